// *** logic/dac_channel_control_regs.sv ***
// DAC channel control register bank with tracking, zero mute and routing
module dac_channel_control_regs
#(
   parameter int NUM_CH = 3
)
(
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          resetn,
   // Serial control pins
   input  wire logic                          ctrl_serial_clock,
   input  wire logic                          ctrl_serial_data,
   input  wire logic                          ctrl_latch,
   // Audio input samples
   input  wire logic                          sample_valid,
   input  wire logic [NUM_CH-1:0][23:0]       sample_left,
   input  wire logic [NUM_CH-1:0][23:0]       sample_right,
   // DAC outputs
   output logic      [NUM_CH-1:0][23:0]       dac_out_left,
   output logic      [NUM_CH-1:0][23:0]       dac_out_right,
   output logic      [NUM_CH-1:0][7:0]        left_atten,
   output logic      [NUM_CH-1:0][7:0]        right_atten,
   output logic      [7:0]                    master_atten,
   output logic      [NUM_CH-1:0]             auto_mute,
   // Register contents
   output logic      [8:0]                    channel_ctrl,
   output logic      [8:0]                    iface_ctrl,
   output logic      [8:0]                    deemph_ctrl,
   output logic      [8:0]                    rate_ctrl,
   output logic      [8:0]                    adc_os_ctrl,
   output logic      [8:0]                    adc_filter_ctrl
);
   localparam int SW = dac_ctrl_pkg::SAMPLE_W;

   // Attenuation map serves exactly three stereo channels
   if (NUM_CH != 3)
   begin
      $error("NUM_CH must be 3 to match the attenuation map");
   end

   // ==========================================
   // Serial receiver
   ctrl_word_if cw ();

   ctrl_serial_rx u_rx
   (
      .core_clk          (core_clk),
      .resetn            (resetn),
      .ctrl_serial_clock (ctrl_serial_clock),
      .ctrl_serial_data  (ctrl_serial_data),
      .ctrl_latch        (ctrl_latch),
      .cw                (cw.rx)
   );

   // Attenuation slot of an address, or -1
   function automatic int atten_slot(input logic [6:0] a);
      case (a)
         dac_ctrl_pkg::ADDR_DAC1_LEFT_ATTEN:  atten_slot = 0;
         dac_ctrl_pkg::ADDR_DAC1_RIGHT_ATTEN: atten_slot = 1;
         dac_ctrl_pkg::ADDR_DAC2_LEFT_ATTEN:  atten_slot = 2;
         dac_ctrl_pkg::ADDR_DAC2_RIGHT_ATTEN: atten_slot = 3;
         dac_ctrl_pkg::ADDR_DAC3_LEFT_ATTEN:  atten_slot = 4;
         dac_ctrl_pkg::ADDR_DAC3_RIGHT_ATTEN: atten_slot = 5;
         dac_ctrl_pkg::ADDR_MASTER_DAC_ATTEN: atten_slot = 6;
         default:                             atten_slot = -1;
      endcase
   endfunction

   // One routed output from a stereo pair
   function automatic logic [SW-1:0] route_pick(input logic [1:0] sel,
                                               input logic [SW-1:0] l,
                                               input logic [SW-1:0] r);
      logic signed [SW:0] sum;
      sum = $signed({l[SW-1], l}) + $signed({r[SW-1], r});
      case (sel)
         dac_ctrl_pkg::ROUTE_LEFT:  route_pick = l;
         dac_ctrl_pkg::ROUTE_RIGHT: route_pick = r;
         dac_ctrl_pkg::ROUTE_AVG:   route_pick = sum[SW:1];
         default:                   route_pick = '0;
      endcase
   endfunction

   // ==========================================
   // Register file
   logic [6:0] wr_addr;
   logic [8:0] wr_data;
   int         wr_slot;
   logic [dac_ctrl_pkg::ATTEN_SLOTS-1:0][7:0] pend_reg, pend_next;
   logic [dac_ctrl_pkg::ATTEN_SLOTS-1:0][7:0] live_reg, live_next;
   logic [8:0] chan_reg, chan_next, iface_reg, iface_next, dmz_reg, dmz_next;
   logic [8:0] rate_reg, rate_next, adcos_reg, adcos_next, adcf_reg, adcf_next;

   assign wr_addr = cw.word[15:9];
   assign wr_data = cw.word[8:0];
   assign wr_slot = atten_slot(wr_addr);

   // Decode committed words; undefined bits are stored as written
   always_comb
   begin
      pend_next  = pend_reg;
      live_next  = live_reg;
      chan_next  = chan_reg;
      iface_next = iface_reg;
      dmz_next   = dmz_reg;
      rate_next  = rate_reg;
      adcos_next = adcos_reg;
      adcf_next  = adcf_reg;
      if (cw.strobe && wr_addr == dac_ctrl_pkg::ADDR_SOFT_RESET)
      begin
         pend_next  = {dac_ctrl_pkg::ATTEN_SLOTS{dac_ctrl_pkg::RST_ATTEN[7:0]}};
         live_next  = {dac_ctrl_pkg::ATTEN_SLOTS{dac_ctrl_pkg::RST_ATTEN[7:0]}};
         chan_next  = dac_ctrl_pkg::RST_CHANNEL_CTRL;
         iface_next = dac_ctrl_pkg::RST_IFACE_CTRL;
         dmz_next   = dac_ctrl_pkg::RST_DEEMPH_MUTE;
         rate_next  = dac_ctrl_pkg::RST_RATE_MASTER;
         adcos_next = dac_ctrl_pkg::RST_ADC_OVERSAMP;
         adcf_next  = dac_ctrl_pkg::RST_ADC_FILTER;
      end
      else if (cw.strobe && wr_slot >= 0)
      begin
         pend_next[wr_slot] = wr_data[7:0];
         if (wr_data[dac_ctrl_pkg::UPDATE_BIT])
         begin
            live_next = pend_next;
         end
      end
      else if (cw.strobe)
      begin
         case (wr_addr)
            dac_ctrl_pkg::ADDR_DAC_CHANNEL_CTRL: chan_next  = wr_data;
            dac_ctrl_pkg::ADDR_AUDIO_IFACE_CTRL: iface_next = wr_data;
            dac_ctrl_pkg::ADDR_DEEMPH_MUTE_ZERO: dmz_next   = wr_data;
            dac_ctrl_pkg::ADDR_RATE_MASTER_PD:   rate_next  = wr_data;
            dac_ctrl_pkg::ADDR_ADC_OVERSAMPLE:   adcos_next = wr_data;
            dac_ctrl_pkg::ADDR_ADC_FILTER_MUTE:  adcf_next  = wr_data;
            default:                             chan_next  = chan_reg;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pend_reg  <= {dac_ctrl_pkg::ATTEN_SLOTS{dac_ctrl_pkg::RST_ATTEN[7:0]}};
         live_reg  <= {dac_ctrl_pkg::ATTEN_SLOTS{dac_ctrl_pkg::RST_ATTEN[7:0]}};
         chan_reg  <= dac_ctrl_pkg::RST_CHANNEL_CTRL;
         iface_reg <= dac_ctrl_pkg::RST_IFACE_CTRL;
         dmz_reg   <= dac_ctrl_pkg::RST_DEEMPH_MUTE;
         rate_reg  <= dac_ctrl_pkg::RST_RATE_MASTER;
         adcos_reg <= dac_ctrl_pkg::RST_ADC_OVERSAMP;
         adcf_reg  <= dac_ctrl_pkg::RST_ADC_FILTER;
      end
      else
      begin
         pend_reg  <= pend_next;
         live_reg  <= live_next;
         chan_reg  <= chan_next;
         iface_reg <= iface_next;
         dmz_reg   <= dmz_next;
         rate_reg  <= rate_next;
         adcos_reg <= adcos_next;
         adcf_reg  <= adcf_next;
      end
   end

   // ==========================================
   // Sample path
   logic track, zero_en;
   logic [3:0] route;
   logic [NUM_CH-1:0][10:0] zcnt_reg, zcnt_next;
   logic [NUM_CH-1:0] mute_reg, mute_next;
   logic [NUM_CH-1:0][SW-1:0] outl_reg, outl_next, outr_reg, outr_next;
   logic [NUM_CH-1:0][7:0] la_reg, la_next, ra_reg, ra_next;
   logic [7:0] ma_reg, ma_next;

   assign track   = chan_reg[dac_ctrl_pkg::ATTEN_TRACK_BIT];
   assign zero_en = chan_reg[dac_ctrl_pkg::ZERO_MUTE_BIT];
   assign route   = chan_reg[dac_ctrl_pkg::ROUTE_LSB +: 4];

   // Per-sample state moves only on a sample, except mute, which clears at once when zero mute is disabled
   always_comb
   begin
      zcnt_next = zcnt_reg;
      mute_next = mute_reg & {NUM_CH{zero_en}}; // Disable lifts mute
      outl_next = outl_reg;
      outr_next = outr_reg;
      la_next   = la_reg;
      ra_next   = ra_reg;
      ma_next   = ma_reg;
      if (sample_valid)
      begin
         ma_next = live_reg[dac_ctrl_pkg::MASTER_SLOT];
         for (int c = 0; c < NUM_CH; c++)
         begin
            la_next[c] = live_reg[2*c];
            ra_next[c] = track ? live_reg[2*c] : live_reg[2*c+1];
            if (sample_left[c] == '0 && sample_right[c] == '0)
            begin
               if (zcnt_reg[c] != dac_ctrl_pkg::ZERO_RUN)
               begin
                  zcnt_next[c] = zcnt_reg[c] + 11'h001;
               end
            end
            else
            begin
               zcnt_next[c] = 11'h000;
            end
            mute_next[c] = zero_en && zcnt_next[c] == dac_ctrl_pkg::ZERO_RUN;
            outl_next[c] = mute_next[c] ? '0 :
                           route_pick(route[1:0], sample_left[c], sample_right[c]);
            outr_next[c] = mute_next[c] ? '0 :
                           route_pick(route[3:2], sample_left[c], sample_right[c]);
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         zcnt_reg <= '0;
         mute_reg <= '0;
         outl_reg <= '0;
         outr_reg <= '0;
         la_reg   <= {NUM_CH{dac_ctrl_pkg::RST_ATTEN[7:0]}};
         ra_reg   <= {NUM_CH{dac_ctrl_pkg::RST_ATTEN[7:0]}};
         ma_reg   <= dac_ctrl_pkg::RST_ATTEN[7:0];
      end
      else
      begin
         zcnt_reg <= zcnt_next;
         mute_reg <= mute_next;
         outl_reg <= outl_next;
         outr_reg <= outr_next;
         la_reg   <= la_next;
         ra_reg   <= ra_next;
         ma_reg   <= ma_next;
      end
   end

   // Outputs
   assign dac_out_left    = outl_reg;
   assign dac_out_right   = outr_reg;
   assign left_atten      = la_reg;
   assign right_atten     = ra_reg;
   assign master_atten    = ma_reg;
   assign auto_mute       = mute_reg;
   assign channel_ctrl    = chan_reg;
   assign iface_ctrl      = iface_reg;
   assign deemph_ctrl     = dmz_reg;
   assign rate_ctrl       = rate_reg;
   assign adc_os_ctrl     = adcos_reg;
   assign adc_filter_ctrl = adcf_reg;

   // ==========================================
   // Checks
   track_right_a : assert property (@(posedge core_clk) disable iff (!resetn)
      sample_valid && track |=> right_atten[0] == $past(live_reg[0]))
      else $error("tracking did not copy left attenuation");
   own_right_a : assert property (@(posedge core_clk) disable iff (!resetn)
      sample_valid && !track |=> right_atten[1] == $past(live_reg[3]))
      else $error("right attenuation not its own");
   atten_hold_a : assert property (@(posedge core_clk) disable iff (!resetn)
      !sample_valid |=> $stable(right_atten) && $stable(left_atten))
      else $error("attenuation moved between samples");
   pend_hold_a : assert property (@(posedge core_clk) disable iff (!resetn)
      cw.strobe && wr_slot >= 0 && !wr_data[8] |=> $stable(live_reg))
      else $error("attenuation applied without update");
   soft_reset_a : assert property (@(posedge core_clk) disable iff (!resetn)
      cw.strobe && wr_addr == dac_ctrl_pkg::ADDR_SOFT_RESET
      |=> chan_reg == dac_ctrl_pkg::RST_CHANNEL_CTRL && rate_reg == dac_ctrl_pkg::RST_RATE_MASTER)
      else $error("reset register did not restore defaults");
   zero_mute_a : assert property (@(posedge core_clk) disable iff (!resetn)
      auto_mute[0] |-> $past(zero_en) && zcnt_reg[0] == 11'h400 && dac_out_left[0] == '0)
      else $error("mute without full zero run");
   unmute_now_a : assert property (@(posedge core_clk) disable iff (!resetn)
      sample_valid && sample_left[0] != '0 |=> !auto_mute[0])
      else $error("non-zero sample left channel muted");
   route_left_a : assert property (@(posedge core_clk) disable iff (!resetn)
      sample_valid && route == 4'h9 && !mute_next[0]
      |=> dac_out_left[0] == $past(sample_left[0]) && dac_out_right[0] == $past(sample_right[0]))
      else $error("default routing wrong");
endmodule

// *** logic/dac_ctrl_pkg.sv ***
// Constants for the DAC channel control register bank
package dac_ctrl_pkg;
   // ==========================================
   // Control word layout
   localparam int WORD_W      = 16;
   localparam int ADDR_W      = 7;
   localparam int DATA_W      = 9;
   localparam int ADDR_LSB    = 9;
   // ==========================================
   // Register addresses
   localparam logic [6:0] ADDR_DAC1_LEFT_ATTEN  = 7'h00;
   localparam logic [6:0] ADDR_DAC1_RIGHT_ATTEN = 7'h01;
   localparam logic [6:0] ADDR_DAC_CHANNEL_CTRL = 7'h02;
   localparam logic [6:0] ADDR_AUDIO_IFACE_CTRL = 7'h03;
   localparam logic [6:0] ADDR_DAC2_LEFT_ATTEN  = 7'h04;
   localparam logic [6:0] ADDR_DAC2_RIGHT_ATTEN = 7'h05;
   localparam logic [6:0] ADDR_DAC3_LEFT_ATTEN  = 7'h06;
   localparam logic [6:0] ADDR_DAC3_RIGHT_ATTEN = 7'h07;
   localparam logic [6:0] ADDR_MASTER_DAC_ATTEN = 7'h08;
   localparam logic [6:0] ADDR_DEEMPH_MUTE_ZERO = 7'h09;
   localparam logic [6:0] ADDR_RATE_MASTER_PD   = 7'h0a;
   localparam logic [6:0] ADDR_ADC_OVERSAMPLE   = 7'h0b;
   localparam logic [6:0] ADDR_ADC_FILTER_MUTE  = 7'h0c;
   localparam logic [6:0] ADDR_SOFT_RESET       = 7'h1f;
   // ==========================================
   // Reset values
   localparam logic [8:0] RST_ATTEN         = 9'h0ff;
   localparam logic [8:0] RST_CHANNEL_CTRL  = 9'h120;
   localparam logic [8:0] RST_IFACE_CTRL    = 9'h000;
   localparam logic [8:0] RST_DEEMPH_MUTE   = 9'h000;
   localparam logic [8:0] RST_RATE_MASTER   = 9'h080;
   localparam logic [8:0] RST_ADC_OVERSAMP  = 9'h040;
   localparam logic [8:0] RST_ADC_FILTER    = 9'h000;
   // ==========================================
   // Field positions
   localparam int UPDATE_BIT     = 8;
   localparam int ATTEN_TRACK_BIT = 3;
   localparam int ZERO_MUTE_BIT  = 4;
   localparam int ROUTE_LSB      = 5;
   localparam int ATTEN_SLOTS    = 7;
   localparam int MASTER_SLOT    = 6;
   // ==========================================
   // Routing codes and zero run
   localparam logic [1:0] ROUTE_MUTE  = 2'h0;
   localparam logic [1:0] ROUTE_LEFT  = 2'h1;
   localparam logic [1:0] ROUTE_RIGHT = 2'h2;
   localparam logic [1:0] ROUTE_AVG   = 2'h3;
   localparam logic [10:0] ZERO_RUN   = 11'h400;
   localparam int SAMPLE_W = 24;
endpackage

// *** logic/ctrl_word_if.sv ***
// Committed control word passed from the serial receiver to the register bank
interface ctrl_word_if;
   logic [15:0] word;
   logic        strobe;
   modport rx   (output word, output strobe);
   modport core (input word, input strobe);
endinterface

// *** logic/ctrl_serial_rx.sv ***
// Three-wire control receiver: synchronise, shift on clock rise, commit on latch rise
module ctrl_serial_rx
(
   // Clock and reset
   input  wire logic  core_clk,
   input  wire logic  resetn,
   // Serial pins
   input  wire logic  ctrl_serial_clock,
   input  wire logic  ctrl_serial_data,
   input  wire logic  ctrl_latch,
   // Committed word
   ctrl_word_if.rx    cw
);
   // ==========================================
   // Synchronisers, three stages per pin
   logic [2:0] sync1_reg, sync2_reg, sync3_reg;
   logic [2:0] level_reg, level_next;
   logic [15:0] shift_reg, shift_next;
   logic [15:0] word_reg, word_next;
   logic        strobe_reg, strobe_next;
   logic        clk_rise, latch_rise;

   // Filtered levels follow once stages two and three agree
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         level_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : level_reg[i];
      end
   end

   assign clk_rise   = level_next[0] & ~level_reg[0];
   assign latch_rise = level_next[2] & ~level_reg[2];

   // Shift and commit
   always_comb
   begin
      shift_next  = shift_reg;
      word_next   = word_reg;
      strobe_next = 1'b0;
      if (clk_rise)
      begin
         shift_next = {shift_reg[14:0], level_next[1]};
      end
      if (latch_rise)
      begin
         word_next   = shift_reg;
         strobe_next = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_reg  <= 3'h0;
         sync2_reg  <= 3'h0;
         sync3_reg  <= 3'h0;
         level_reg  <= 3'h0;
         shift_reg  <= 16'h0000;
         word_reg   <= 16'h0000;
         strobe_reg <= 1'b0;
      end
      else
      begin
         sync1_reg  <= {ctrl_latch, ctrl_serial_data, ctrl_serial_clock};
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         level_reg  <= level_next;
         shift_reg  <= shift_next;
         word_reg   <= word_next;
         strobe_reg <= strobe_next;
      end
   end

   assign cw.word   = word_reg;
   assign cw.strobe = strobe_reg;

   // ==========================================
   // Checks
   strobe_on_latch_a : assert property (@(posedge core_clk) disable iff (!resetn)
      strobe_reg |-> $past(latch_rise))
      else $error("commit without latch rise");
   word_from_shift_a : assert property (@(posedge core_clk) disable iff (!resetn)
      latch_rise |=> (word_reg == $past(shift_reg)) && strobe_reg)
      else $error("committed word differs from shifted bits");
endmodule

// *** test/ctrl_host.sv ***
// Host-side model that drives the three-wire control link
module ctrl_host
(
   // Control link pins
   output logic ctrl_serial_clock,
   output logic ctrl_serial_data,
   output logic ctrl_latch
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Idle levels: clock and latch low, data parked
   initial
   begin
      ctrl_serial_clock = 1'b0;
      ctrl_serial_data  = 1'b1;
      ctrl_latch        = 1'b0;
   end

   // ==========================================
   // One 16-bit word, MSB first, 200 ns high and low phases
   task automatic send(input logic [15:0] word);
      int i;
      #13;
      for (i = 15; i >= 0; i--)
      begin
         ctrl_serial_data = word[i];
         #200 ctrl_serial_clock = 1'b1;
         #200 ctrl_serial_clock = 1'b0;
      end
      // Data no longer valid after the last clock
      ctrl_serial_data = ~ctrl_serial_data;
      #400 ctrl_latch = 1'b1;
      #400 ctrl_latch = 1'b0;
      #400;
   endtask
endmodule

// *** test/dac_channel_control_regs_bench.sv ***
// Self-checking bench for the DAC channel control register bank
`define CHK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("[ERR] %s expected %h seen %h", what, exp, got); \
      end \
   end

module dac_channel_control_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Signals
   logic                 core_clk;
   logic                 resetn;
   logic                 ctrl_serial_clock;
   logic                 ctrl_serial_data;
   logic                 ctrl_latch;
   logic                 sample_valid;
   logic [2:0][23:0]     sample_left;
   logic [2:0][23:0]     sample_right;
   logic [2:0][23:0]     dac_out_left;
   logic [2:0][23:0]     dac_out_right;
   logic [2:0][7:0]      left_atten;
   logic [2:0][7:0]      right_atten;
   logic [7:0]           master_atten;
   logic [2:0]           auto_mute;
   logic [8:0]           channel_ctrl;
   logic [8:0]           iface_ctrl;
   logic [8:0]           deemph_ctrl;
   logic [8:0]           rate_ctrl;
   logic [8:0]           adc_os_ctrl;
   logic [8:0]           adc_filter_ctrl;
   int                   error_cnt;
   int                   compares;
   int                   i;

   // ==========================================
   // Instances
   ctrl_host ctrl_host_i
   (
      .ctrl_serial_clock (ctrl_serial_clock),
      .ctrl_serial_data  (ctrl_serial_data),
      .ctrl_latch        (ctrl_latch)
   );

   dac_channel_control_regs #(.NUM_CH(3)) dac_channel_control_regs_i
   (
      .core_clk          (core_clk),
      .resetn            (resetn),
      .ctrl_serial_clock (ctrl_serial_clock),
      .ctrl_serial_data  (ctrl_serial_data),
      .ctrl_latch        (ctrl_latch),
      .sample_valid      (sample_valid),
      .sample_left       (sample_left),
      .sample_right      (sample_right),
      .dac_out_left      (dac_out_left),
      .dac_out_right     (dac_out_right),
      .left_atten        (left_atten),
      .right_atten       (right_atten),
      .master_atten      (master_atten),
      .auto_mute         (auto_mute),
      .channel_ctrl      (channel_ctrl),
      .iface_ctrl        (iface_ctrl),
      .deemph_ctrl       (deemph_ctrl),
      .rate_ctrl         (rate_ctrl),
      .adc_os_ctrl       (adc_os_ctrl),
      .adc_filter_ctrl   (adc_filter_ctrl)
   );

   // ==========================================
   // Clock and watchdog
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial
   begin
      #4_000_000;
      error_cnt++;
      close_out();
   end

   // ==========================================
   // Helpers
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Serial write, then wait out the sync and commit latency
   task automatic wr(input logic [6:0] addr, input logic [8:0] data);
      ctrl_host_i.send({addr, data});
      repeat (10) @(negedge core_clk);
   endtask

   // One stereo sample; channels 1 and 2 carry fixed non-zero data
   task automatic smp(input logic [23:0] l, input logic [23:0] r);
      @(negedge core_clk);
      sample_left  = {24'h00_0010, 24'h00_0010, l};
      sample_right = {24'h00_0020, 24'h00_0020, r};
      sample_valid = 1'b1;
      @(negedge core_clk);
      sample_valid = 1'b0;
      @(negedge core_clk);
   endtask

   // Expected output for one routing code
   function automatic logic [23:0] pick(input logic [1:0] c, input logic [23:0] l,
                                        input logic [23:0] r);
      logic [24:0] s;
      s = {l[23], l} + {r[23], r};
      case (c)
         2'h0:    pick = 24'h00_0000;
         2'h1:    pick = l;
         2'h2:    pick = r;
         default: pick = s[24:1];
      endcase
   endfunction

   // ==========================================
   // Main sequence
   initial
   begin
      error_cnt    = 0;
      compares     = 0;
      resetn       = 1'b0;
      sample_valid = 1'b0;
      sample_left  = '0;
      sample_right = '0;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      @(negedge core_clk);

      // Reset values
      `CHK("channel_ctrl", 9'h120, channel_ctrl)
      `CHK("rate_ctrl", 9'h080, rate_ctrl)
      `CHK("adc_os_ctrl", 9'h040, adc_os_ctrl)
      `CHK("left_atten", 8'hff, left_atten[0])
      $display("test reset_values done");

      // Plain registers, undefined bits stored as written, then an unmapped address
      wr(dac_ctrl_pkg::ADDR_AUDIO_IFACE_CTRL, 9'h0a5);
      wr(dac_ctrl_pkg::ADDR_DEEMPH_MUTE_ZERO, 9'h0a6);
      wr(dac_ctrl_pkg::ADDR_RATE_MASTER_PD, 9'h0a7);
      wr(dac_ctrl_pkg::ADDR_ADC_OVERSAMPLE, 9'h140);
      wr(dac_ctrl_pkg::ADDR_ADC_FILTER_MUTE, 9'h04f);
      wr(7'h0d, 9'h1ff);
      `CHK("iface_ctrl", 9'h0a5, iface_ctrl)
      `CHK("deemph_ctrl", 9'h0a6, deemph_ctrl)
      `CHK("rate_ctrl", 9'h0a7, rate_ctrl)
      `CHK("adc_os_ctrl", 9'h140, adc_os_ctrl)
      `CHK("adc_filter_ctrl", 9'h04f, adc_filter_ctrl)
      `CHK("channel_ctrl", 9'h120, channel_ctrl)
      $display("test register_writes done");

      // Pending attenuation, shared update bit
      wr(dac_ctrl_pkg::ADDR_DAC1_LEFT_ATTEN, 9'h010);
      smp(24'h00_0001, 24'h00_0002);
      `CHK("left_atten", 8'hff, left_atten[0])
      wr(dac_ctrl_pkg::ADDR_DAC1_RIGHT_ATTEN, 9'h120);
      wr(dac_ctrl_pkg::ADDR_MASTER_DAC_ATTEN, 9'h133);
      smp(24'h00_0001, 24'h00_0002);
      `CHK("left_atten", 8'h10, left_atten[0])
      `CHK("right_atten", 8'h20, right_atten[0])
      `CHK("master_atten", 8'h33, master_atten)
      $display("test pending_atten done");

      // Tracking on and off, no attenuation rewrite
      wr(dac_ctrl_pkg::ADDR_DAC_CHANNEL_CTRL, 9'h128);
      `CHK("right_atten", 8'h20, right_atten[0])
      smp(24'h00_0001, 24'h00_0002);
      `CHK("right_atten", 8'h10, right_atten[0])
      `CHK("left_atten", 8'h10, left_atten[0])
      wr(dac_ctrl_pkg::ADDR_DAC_CHANNEL_CTRL, 9'h120);
      smp(24'h00_0001, 24'h00_0002);
      `CHK("right_atten", 8'h20, right_atten[0])
      $display("test tracking done");

      // Every routing code, negative average rounds down
      for (i = 0; i < 16; i++)
      begin
         wr(dac_ctrl_pkg::ADDR_DAC_CHANNEL_CTRL, {i[3:0], 5'h00});
         smp(24'hff_fffd, 24'h00_0002);
         `CHK("dac_out_left", pick(i[1:0], 24'hff_fffd, 24'h00_0002), dac_out_left[0])
         `CHK("dac_out_right", pick(i[3:2], 24'hff_fffd, 24'h00_0002), dac_out_right[0])
      end
      $display("test routing done");

      // Zero run with mute disabled, then enabled
      wr(dac_ctrl_pkg::ADDR_DAC_CHANNEL_CTRL, 9'h120);
      for (i = 0; i < 1024; i++)
         smp(24'h00_0000, 24'h00_0000);
      `CHK("auto_mute", 1'b0, auto_mute[0])
      wr(dac_ctrl_pkg::ADDR_DAC_CHANNEL_CTRL, 9'h130);
      smp(24'h00_0000, 24'h00_0000);
      `CHK("auto_mute", 1'b1, auto_mute[0])
      `CHK("auto_mute ch1", 1'b0, auto_mute[1])
      `CHK("dac_out_left", 24'h00_0000, dac_out_left[0])
      smp(24'h00_0005, 24'h00_0000);
      `CHK("auto_mute", 1'b0, auto_mute[0])
      `CHK("dac_out_left", 24'h00_0005, dac_out_left[0])
      for (i = 0; i < 1023; i++)
         smp(24'h00_0000, 24'h00_0000);
      `CHK("auto_mute", 1'b0, auto_mute[0])
      smp(24'h00_0000, 24'h00_0000);
      `CHK("auto_mute", 1'b1, auto_mute[0])
      $display("test zero_mute done");

      // Soft reset restores every default
      wr(dac_ctrl_pkg::ADDR_SOFT_RESET, 9'h000);
      `CHK("channel_ctrl", 9'h120, channel_ctrl)
      `CHK("iface_ctrl", 9'h000, iface_ctrl)
      `CHK("rate_ctrl", 9'h080, rate_ctrl)
      `CHK("adc_os_ctrl", 9'h040, adc_os_ctrl)
      `CHK("auto_mute", 1'b0, auto_mute[0])
      smp(24'h00_0001, 24'h00_0002);
      `CHK("left_atten", 8'hff, left_atten[0])
      `CHK("master_atten", 8'hff, master_atten)
      $display("test soft_reset done");
      close_out();
   end
endmodule
